// ---- sim/host_alert_model.sv ----
module host_alert_model (
    // Clock, reset and the alert line.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic irq_i,
    // Alerts taken so far.
    output int alerts_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic seen_q;
    // The host takes one alert per rising edge, since the line is a level.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_q <= 1'b0;
            alerts_o <= 0;
        end else begin
            seen_q <= irq_i;
            if (irq_i && !seen_q) alerts_o <= alerts_o + 1;
        end
    end
endmodule : host_alert_model

// ---- sim/low_power_activity_detect_monitor.sv ----
module low_power_activity_detect_monitor (
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Bus handshakes.
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Alerts.
    input wire logic irq_o,
    input wire logic record_active_o,
    input wire logic [7:0] record_config_o,
    input wire logic monitor_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Answers hold until taken; a busy port refuses a second request.
    b_hold_a: assert property ($fell(s_axi_bvalid_o) |->
        $past(s_axi_bready_i)) else $error("bresp dropped");
    r_hold_a: assert property ($fell(s_axi_rvalid_o) |->
        $past(s_axi_rready_i)) else $error("rdata dropped");
    wr_busy_a: assert property (s_axi_bvalid_o |->
        !s_axi_awready_o && !s_axi_wready_o) else $error("write ready early");
    rd_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read ready early");
    // Software-held state only moves on a completed write, or on a wake.
    cfg_write_a: assert property ($changed(record_config_o) |->
        $rose(s_axi_bvalid_o)) else $error("config moved alone");
    rec_stop_a: assert property ($fell(record_active_o) |-> s_axi_bvalid_o)
        else $error("record stopped alone");
    irq_clear_a: assert property ($fell(irq_o) |-> $past(s_axi_bvalid_o))
        else $error("irq fell alone");
    mon_stop_a: assert property ($fell(monitor_active_o) |->
        $past(s_axi_bvalid_o) || record_active_o) else $error("monitor left");
    cover property ($rose(irq_o));
    cover property ($rose(record_active_o));
    cover property ($rose(monitor_active_o));
endmodule : low_power_activity_detect_monitor

bind low_power_activity_detect low_power_activity_detect_monitor i_low_power_activity_detect_monitor (.*);

// ---- sim/low_power_activity_detect_tb.sv ----
module low_power_activity_detect_tb
    import low_power_activity_detect_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, analog_valid_i = 1'b0;
    logic [63:0] analog_sample_i = 64'h0, dmic_sample_i = 64'h0;
    logic dmic_valid_i = 1'b0, ph = 1'b0, src, ultra;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, irq_o, record_active_o, monitor_active_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp, ch, m;
    logic [7:0] record_config_o;
    logic [15:0] amp;
    logic [31:0] seed = 32'h0AD1;
    int fails = 0, n_compared = 0, alerts, n_irq = 0;

    low_power_activity_detect i_low_power_activity_detect (.*);
    host_alert_model i_host_alert_model (.clk_sys_i, .rst_n_i, .irq_i(irq_o), .alerts_o(alerts));

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Status expected after one detection, all mask bits set.
    function automatic logic [31:0] exp_st(input logic [1:0] md, input logic u);
        logic [31:0] d;
        d = u ? 32'h2 : 32'h1;
        case (md)
            ALERT_IRQ: return d;
            ALERT_WAKE: return 32'h4;
            ALERT_BOTH: return d | 32'h4;
            default: return 32'h0;
        endcase
    endfunction : exp_st

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // Address and data go out together; each drops once its ready is seen.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (s_axi_bvalid_o !== 1'b1);
        resp = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (s_axi_rvalid_o !== 1'b1);
        rd = s_axi_rdata_o;
        resp = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask : rdr

    // Noise everywhere but the watched channel, so a routing slip shows.
    task automatic feed(input int n, input logic loud);
        logic [63:0] t;
        logic [63:0] nz;
        for (int k = 0; k < n; k++) begin
            t = {rnd(), rnd()};
            nz = {rnd(), rnd()};
            ph = ~ph;
            t[ch*16 +: 16] = !loud ? 16'h0000 : ph ? amp : -amp;
            @(posedge clk_sys_i);
            analog_sample_i <= src ? nz : t;
            dmic_sample_i <= src ? t : nz;
            analog_valid_i <= 1'b1;
            dmic_valid_i <= 1'b1;
            @(posedge clk_sys_i);
            analog_valid_i <= 1'b0;
            dmic_valid_i <= 1'b0;
        end
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask : feed

    task automatic end_of_test();
        if (fails == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // A hang costs far more than the roughly 1150 cycles of the run.
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            rdr(8'(a * 4));
            chk("reset", rd, a == 4 ? 32'h100 : a == 5 ? 32'h0400 : 32'h0);
        end
        rdr(8'h1C);
        chk("unmapped", {rd[29:0], resp}, {30'h0, RESP_SLVERR});
        wr(OFS_STATE, 32'hFFFFFFFF);
        chk("readonly", resp, RESP_SLVERR);
        wr(OFS_THRESHOLD, 32'hABCD_0400);
        rdr(OFS_THRESHOLD);
        chk("threshold", rd, 32'h0400);
        // Every alert mode and channel, source and detector drawn at random.
        for (int i = 0; i < 16; i++) begin
            m = i[1:0];
            ch = i[3:2];
            rd = rnd();
            src = rd[0];
            ultra = rd[1];
            amp = {4'h0, rd[27:16]} | 16'h0401;
            if (i == 0) amp = 16'h0401;
            wr(OFS_CTRL, 32'h0);
            wr(OFS_IRQ_STATUS, 32'h7);
            wr(OFS_ALERT, {24'h0, m, ch, 4'h0});
            wr(OFS_IRQ_MASK, 32'h7);
            wr(OFS_RECORD_CFG, {24'h0, rd[31:24]});
            wr(OFS_CTRL, {27'h0, src, ultra, !ultra, 2'h0});
            feed(8, 1'b0);
            chk("quiet", irq_o, 32'h0);
            chk("monitor", monitor_active_o, 32'h1);
            feed(3, 1'b1);
            chk("short", irq_o, 32'h0);
            feed(1, 1'b1);
            chk("irq", irq_o, {31'h0, |exp_st(m, ultra)});
            chk("record", record_active_o, {31'h0, m == ALERT_WAKE || m == ALERT_BOTH});
            chk("config", record_config_o, {24'h0, rd[31:24]});
            n_irq += (m != ALERT_QUIET);
            rdr(OFS_IRQ_STATUS);
            chk("status", rd, exp_st(m, ultra));
            wr(OFS_IRQ_MASK, 32'h0);
            repeat (2) @(posedge clk_sys_i);
            chk("masked", irq_o, 32'h0);
        end
        chk("alerts", alerts, n_irq);
        end_of_test();
    end
endmodule : low_power_activity_detect_tb

// ---- src/activity_detector.sv ----
module activity_detector
    import low_power_activity_detect_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Detector link.
    detect_if.det det
);

    // ------------------------------------------------------------------
    // Level measure
    // ------------------------------------------------------------------
    logic [SAMPLE_W-1:0] prev_q;
    logic [3:0] run_q;
    logic [SAMPLE_W-1:0] diff;
    logic [SAMPLE_W-1:0] level;
    logic active;
    logic above;

    // Voice uses the raw magnitude; ultrasonic uses the first difference,
    // a crude high-pass that favours content near the top of the band.
    always_comb begin
        diff = det.sample - prev_q;
        level = det.ultra_mode ? abs_mag(diff) : abs_mag(det.sample);
        active = det.voice_mode || det.ultra_mode;
        above = level > det.threshold;
    end

    // ------------------------------------------------------------------
    // Dwell counter
    // ------------------------------------------------------------------
    // A hit needs HIT_COUNT loud samples in a row, which rejects clicks.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= 16'h0000;
            run_q <= 4'h0;
            det.hit <= 1'b0;
        end else begin
            det.hit <= 1'b0;
            if (!active) begin
                prev_q <= 16'h0000;
                run_q <= 4'h0;
            end else if (det.sample_valid) begin
                prev_q <= det.sample;
                if (!above) begin
                    run_q <= 4'h0;
                end else if (run_q != HIT_COUNT) begin
                    run_q <= run_q + 4'h1;
                    det.hit <= (run_q == HIT_COUNT - 4'h1);
                end
            end
        end
    end

endmodule : activity_detector

// ---- src/detect_if.sv ----
interface detect_if;
    import low_power_activity_detect_pkg::*;

    logic [SAMPLE_W-1:0] sample;
    logic sample_valid;
    logic voice_mode;
    logic ultra_mode;
    logic [SAMPLE_W-1:0] threshold;
    logic hit;

    // Control side feeds samples and modes, detector returns hits.
    modport ctrl (output sample, sample_valid, voice_mode, ultra_mode, threshold, input hit);
    modport det (input sample, sample_valid, voice_mode, ultra_mode, threshold, output hit);
endinterface : detect_if

// ---- src/low_power_activity_detect.sv ----
module low_power_activity_detect
    import low_power_activity_detect_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Record-path samples, four channels packed, from both front ends.
    input wire logic [CHAN_N*SAMPLE_W-1:0] analog_sample_i,
    input wire logic analog_valid_i,
    input wire logic [CHAN_N*SAMPLE_W-1:0] dmic_sample_i,
    input wire logic dmic_valid_i,
    // Alerts and record control.
    output logic irq_o,
    output logic record_active_o,
    output logic [7:0] record_config_o,
    output logic monitor_active_o
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic voice_detect_enable_q;
    logic ultrasonic_detect_enable_q;
    logic digital_source_q;
    logic [1:0] detect_alert_select_q;
    logic [1:0] detect_channel_select_q;
    logic [2:0] irq_status_q;
    logic [2:0] irq_mask_q;
    logic [SAMPLE_W-1:0] threshold_q;
    logic [7:0] record_cfg_q;
    logic record_q;
    low_power_activity_detect_state_type state_q;

    // ------------------------------------------------------------------
    // Bus handshake state
    // ------------------------------------------------------------------
    logic awready_q;
    logic wready_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic irq_q;

    logic wr_fire;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] alert_word;
    logic [DATA_W-1:0] state_word;
    logic [DATA_W-1:0] merged;
    logic [DATA_W-1:0] thr_merged;
    logic voice_mode;
    logic ultra_mode;
    logic voice_hit;
    logic ultra_hit;
    logic wants_irq;
    logic wants_wake;
    logic wake_now;
    logic rec_write;

    detect_if det_bus ();

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    // Address and data are taken independently in either order; the write
    // is performed once both are held and no response is outstanding.
    assign wr_fire = !awready_q && !wready_q && !bvalid_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            awready_q <= 1'b1;
            awaddr_q <= 8'h00;
        end else if (awready_q && s_axi_awvalid_i) begin
            awready_q <= 1'b0;
            awaddr_q <= s_axi_awaddr_i;
        end else if (bvalid_q && s_axi_bready_i) begin
            awready_q <= 1'b1;
        end
    end

    // Data channel holding register.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wready_q <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (wready_q && s_axi_wvalid_i) begin
            wready_q <= 1'b0;
            wdata_q <= s_axi_wdata_i;
            wstrb_q <= s_axi_wstrb_i;
        end else if (bvalid_q && s_axi_bready_i) begin
            wready_q <= 1'b1;
        end
    end

    // Response: writes to read-only or unmapped words answer SLVERR.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            unique case (awaddr_q)
                OFS_CTRL, OFS_ALERT, OFS_IRQ_STATUS, OFS_IRQ_MASK,
                OFS_THRESHOLD, OFS_RECORD_CFG: bresp_q <= RESP_OKAY;
                default: bresp_q <= RESP_SLVERR;
            endcase
        end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_RECORD_BIT] = record_q;
        ctrl_word[CTRL_VOICE_BIT] = voice_detect_enable_q;
        ctrl_word[CTRL_ULTRA_BIT] = ultrasonic_detect_enable_q;
        ctrl_word[CTRL_DIGITAL_BIT] = digital_source_q;
        alert_word = 32'h0000_0000;
        alert_word[ALERT_MODE_LSB +: 2] = detect_alert_select_q;
        alert_word[ALERT_CHAN_LSB +: 2] = detect_channel_select_q;
        state_word = 32'h0000_0000;
        state_word[0] = voice_mode;
        state_word[1] = ultra_mode;
        state_word[2] = record_q;
        state_word[STATE_CHAN_LSB +: 2] = detect_channel_select_q;
        state_word[STATE_FSM_LSB +: 3] = state_q;
        merged = apply_strb(awaddr_q == OFS_CTRL ? ctrl_word : alert_word, wdata_q, wstrb_q);
        thr_merged = apply_strb({16'h0000, threshold_q}, wdata_q, wstrb_q);
    end

    // Enables, source select and alert fields.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            voice_detect_enable_q <= 1'b0;
            ultrasonic_detect_enable_q <= 1'b0;
            digital_source_q <= 1'b0;
            detect_alert_select_q <= ALERT_IRQ;
            detect_channel_select_q <= 2'h0;
        end else if (wr_fire && awaddr_q == OFS_CTRL) begin
            voice_detect_enable_q <= merged[CTRL_VOICE_BIT];
            ultrasonic_detect_enable_q <= merged[CTRL_ULTRA_BIT];
            digital_source_q <= merged[CTRL_DIGITAL_BIT];
        end else if (wr_fire && awaddr_q == OFS_ALERT) begin
            detect_alert_select_q <= merged[ALERT_MODE_LSB +: 2];
            detect_channel_select_q <= merged[ALERT_CHAN_LSB +: 2];
        end
    end

    // Mask, threshold and the recording setup applied at wake.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_mask_q <= 3'h0;
            threshold_q <= THRESHOLD_RST;
            record_cfg_q <= RECORD_CFG_RST;
        end else if (wr_fire) begin
            if (awaddr_q == OFS_IRQ_MASK && wstrb_q[0]) begin
                irq_mask_q <= wdata_q[2:0];
            end
            if (awaddr_q == OFS_THRESHOLD) begin
                threshold_q <= thr_merged[SAMPLE_W-1:0];
            end
            if (awaddr_q == OFS_RECORD_CFG && wstrb_q[0]) begin
                record_cfg_q <= wdata_q[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Detector feed
    // ------------------------------------------------------------------
    // Voice takes priority if software breaks the one-mode-at-a-time
    // convention, so the two measures never mix.
    assign voice_mode = voice_detect_enable_q;
    assign ultra_mode = ultrasonic_detect_enable_q && !voice_detect_enable_q;

    always_comb begin
        det_bus.voice_mode = voice_mode;
        det_bus.ultra_mode = ultra_mode;
        det_bus.threshold = threshold_q;
        if (digital_source_q) begin
            det_bus.sample = chan_pick(dmic_sample_i, detect_channel_select_q);
            det_bus.sample_valid = dmic_valid_i;
        end else begin
            det_bus.sample = chan_pick(analog_sample_i, detect_channel_select_q);
            det_bus.sample_valid = analog_valid_i;
        end
    end

    activity_detector i_activity_detector (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .det(det_bus)
    );

    // ------------------------------------------------------------------
    // Alert decision
    // ------------------------------------------------------------------
    always_comb begin
        voice_hit = det_bus.hit && voice_mode;
        ultra_hit = det_bus.hit && ultra_mode;
        wants_irq = detect_alert_select_q == ALERT_IRQ || detect_alert_select_q == ALERT_BOTH;
        wants_wake = detect_alert_select_q == ALERT_WAKE || detect_alert_select_q == ALERT_BOTH;
        wake_now = det_bus.hit && wants_wake && state_q == ST_MONITOR;
        rec_write = wr_fire && awaddr_q == OFS_CTRL && wstrb_q[0];
    end

    // Sticky events: a new event in the clearing cycle survives.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status_q <= 3'h0;
        end else begin
            irq_status_q <= (irq_status_q & ~((wr_fire && awaddr_q == OFS_IRQ_STATUS
                && wstrb_q[0]) ? wdata_q[2:0] : 3'h0))
                | {wake_now, ultra_hit && wants_irq, voice_hit && wants_irq};
        end
    end

    // Interrupt level output.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // Monitor and record sequence
    // ------------------------------------------------------------------
    // Recording stays on until software clears it; a wake in the same
    // cycle as that clear keeps recording on.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            record_q <= 1'b0;
        end else if (wake_now) begin
            record_q <= 1'b1;
        end else if (rec_write) begin
            record_q <= merged[CTRL_RECORD_BIT];
        end
    end

    // Sequencer state; monitoring ends once a wake has started recording.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (voice_mode || ultra_mode) begin
                        state_q <= ST_MONITOR;
                    end
                end
                ST_MONITOR: begin
                    if (wake_now) begin
                        state_q <= ST_RECORD;
                    end else if (!voice_mode && !ultra_mode) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_RECORD: begin
                    if (!record_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    // One read at a time; data follows one cycle after the address.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (arready_q && s_axi_arvalid_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            unique case (s_axi_araddr_i)
                OFS_CTRL: rdata_q <= ctrl_word;
                OFS_ALERT: rdata_q <= alert_word;
                OFS_IRQ_STATUS: rdata_q <= {29'h0000_0000, irq_status_q};
                OFS_IRQ_MASK: rdata_q <= {29'h0000_0000, irq_mask_q};
                OFS_STATE: rdata_q <= state_word;
                OFS_THRESHOLD: rdata_q <= {16'h0000, threshold_q};
                OFS_RECORD_CFG: rdata_q <= {24'h00_0000, record_cfg_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready_i) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rdata_o = rdata_q;
    assign s_axi_rresp_o = rresp_q;
    assign irq_o = irq_q;
    assign record_active_o = record_q;
    assign record_config_o = record_cfg_q;
    assign monitor_active_o = state_q[1];

endmodule : low_power_activity_detect

// ---- src/low_power_activity_detect_pkg.sv ----
package low_power_activity_detect_pkg;

    // ------------------------------------------------------------------
    // Bus and data widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SAMPLE_W = 16;
    localparam int CHAN_N = 4;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ALERT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_THRESHOLD = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RECORD_CFG = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_RECORD_BIT = 0;
    localparam int CTRL_VOICE_BIT = 2;
    localparam int CTRL_ULTRA_BIT = 3;
    localparam int CTRL_DIGITAL_BIT = 4;
    localparam int ALERT_CHAN_LSB = 4;
    localparam int ALERT_MODE_LSB = 6;
    localparam int IRQ_VOICE_BIT = 0;
    localparam int IRQ_ULTRA_BIT = 1;
    localparam int IRQ_WAKE_BIT = 2;
    localparam int STATE_CHAN_LSB = 4;
    localparam int STATE_FSM_LSB = 8;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [SAMPLE_W-1:0] THRESHOLD_RST = 16'h0400;
    localparam logic [7:0] RECORD_CFG_RST = 8'h00;
    localparam logic [3:0] HIT_COUNT = 4'h4;

    // ------------------------------------------------------------------
    // Alert modes and bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] ALERT_IRQ = 2'h0;
    localparam logic [1:0] ALERT_WAKE = 2'h1;
    localparam logic [1:0] ALERT_BOTH = 2'h2;
    localparam logic [1:0] ALERT_QUIET = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_MONITOR = 3'h2,
        ST_RECORD = 3'h4
    } low_power_activity_detect_state_type;

    // ------------------------------------------------------------------
    // Shared functions
    // ------------------------------------------------------------------
    // Magnitude of a signed sample; the most negative code saturates.
    function automatic logic [SAMPLE_W-1:0] abs_mag(input logic [SAMPLE_W-1:0] v);
        logic [SAMPLE_W-1:0] n;
        n = ~v + 16'h0001;
        if (!v[SAMPLE_W-1]) begin
            abs_mag = v;
        end else if (n[SAMPLE_W-1]) begin
            abs_mag = 16'h7FFF;
        end else begin
            abs_mag = n;
        end
    endfunction : abs_mag

    // Picks one channel out of a packed group of four.
    function automatic logic [SAMPLE_W-1:0] chan_pick(
        input logic [CHAN_N*SAMPLE_W-1:0] d, input logic [1:0] sel);
        chan_pick = d[sel*SAMPLE_W +: SAMPLE_W];
    endfunction : chan_pick

    // Merges write data into a register under the byte strobes.
    function automatic logic [DATA_W-1:0] apply_strb(
        input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] wd, input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
        apply_strb = old;
    endfunction : apply_strb

endpackage : low_power_activity_detect_pkg
